// ==== logic/pmcdr_pkg.sv ====
// package: offsets, field positions, reset values and carriers for the tuning and capability bank
package pmcdr_pkg;
  // ---------------------------------------------------------------------------
  // configuration offsets (byte addresses)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFS_VENDOR_LO = 8'h00;
  localparam logic [7:0] OFS_VENDOR_HI = 8'h01;
  localparam logic [7:0] OFS_DEVICE_LO = 8'h02;
  localparam logic [7:0] OFS_DEVICE_HI = 8'h03;
  localparam logic [7:0] OFS_TEST_TUNING_CONTROL = 8'h93;
  localparam logic [7:0] OFS_CAPABILITY_IDENTIFIER = 8'ha0;
  localparam logic [7:0] OFS_NEXT_ITEM_POINTER = 8'ha1;
  localparam logic [7:0] OFS_POWER_CAP_LO = 8'ha2;
  localparam logic [7:0] OFS_POWER_CAP_HI = 8'ha3;
  // ---------------------------------------------------------------------------
  // test/tuning control fields
  // ---------------------------------------------------------------------------
  localparam int BIT_ID_MASK_SELECT = 7;
  localparam int BIT_TUNE_RSVD = 6;
  localparam int BIT_STATUS_CHANGE_ROUTING = 5;
  localparam int BIT_DELAYED_TXN_DISABLE = 4;
  localparam int BIT_RETRY_LATENCY_EXTEND = 3;
  localparam int BIT_CARD_DISCARD_SEL = 2;
  localparam int BIT_HOST_DISCARD_SEL = 1;
  localparam int BIT_VIDEO_MODEL_DISABLE = 0;
  localparam logic [7:0] TUNE_RESET = 8'h60;
  localparam logic [7:0] TUNE_FORCE_ONE = 8'h40;
  // ---------------------------------------------------------------------------
  // capability header values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CAP_ID_VALUE = 8'h01;
  localparam logic [7:0] NEXT_PTR_VALUE = 8'h00;
  localparam logic [15:0] POWER_CAP_RESET = 16'hfe12;
  localparam logic [3:0] WAKE_FIXED_STATES = 4'hf;
  localparam logic [1:0] STATE_TWO_ONE_SUPPORT = 2'h3;
  localparam logic [2:0] CAP_RSVD_VALUE = 3'h0;
  localparam logic DEVICE_INIT_NEEDED = 1'b1;
  localparam logic WAKE_NEEDS_CLOCK = 1'b0;
  localparam logic [2:0] PM_VERSION = 3'h2;
  localparam int BIT_WAKE_D3COLD = 15;
  localparam int BIT_AUX_POWER = 4;
  // ---------------------------------------------------------------------------
  // legacy card register fields and tuning counts
  // ---------------------------------------------------------------------------
  localparam int BIT_LEGACY803_ROUTE = 4;
  localparam logic [3:0] LEGACY805_ROUTE_VALUE = 4'h0;
  localparam int RETRY_SHORT = 16;
  localparam int RETRY_LONG = 64;
  localparam int DISCARD_EXP_SHORT = 10;
  localparam int DISCARD_EXP_LONG = 15;
  localparam logic [7:0] ALL_ONES_BYTE = 8'hff;
  // ---------------------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pmcdr_cfg_req_t;
  typedef struct packed {
    logic        delayed_txn_disable;
    logic [6:0]  retry_latency;
    logic [15:0] card_discard_limit;
    logic [15:0] host_discard_limit;
    logic        video_model_enable;
  } pmcdr_tuning_t;
endpackage

// ==== logic/pmcdr_regs.sv ====
// tuning register and power-management capability header behind configuration accesses
//
// Operation
// - id_mask_select set makes vendor and device id reads return all ones.
// - bit 6 of the tuning register always reads one.
// - status_change_routing picks legacy 803 bit 4 or legacy 805 bits 7-4 zero.
// - tuning bit 4 disables delayed transaction handling for target accesses.
// - tuning bit 3 extends target retry latency from 16 to 64.
// - card side discard timeout is 2^10 when set, 2^15 when clear.
// - host side discard timeout is 2^10 when set, 2^15 when clear.
// - tuning bit 0 clear enables the standard video register model.
// - capability identifier at A0h is read-only, returns 01h.
// - next-item pointer at A1h is read-only, returns 00h.
// - wake from D3cold bit 15 is writable and resets to one.
// - capability bits 14-11 read as ones.
// - capability bits 10 and 9 read as ones.
// - capability bits 8-6 read as zeros.
// - capability bit 5 reads as one.
// - capability bit 4 mirrors writable bit 15.
// - capability bit 3 reads as zero.
// - capability bits 2-0 read 010b.
`timescale 1ns/100ps
module pmcdr_regs
  import pmcdr_pkg::*;
#(
  parameter logic [15:0] VENDOR_ID = 16'h1234,  // arbitrary value
  parameter logic [15:0] DEVICE_ID = 16'h5678,  // arbitrary value
  parameter int          LIMIT_W   = 16
) (
  input  wire logic           clk,
  input  wire logic           srst,
  input  wire pmcdr_cfg_req_t cfg_req,
  output logic [7:0]          cfg_rdata,
  output logic                cfg_rvalid,
  input  wire logic [7:0]     legacy_card_reg803,
  input  wire logic [7:0]     legacy_card_reg805,
  input  wire logic           status_change_event,
  output logic                status_change_to_host,
  output pmcdr_tuning_t       tuning
);
  // ---------------------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------------------
  // the long discard limit is 2^15 and must fit the limit field
  if (LIMIT_W != 16) begin : g_bad_width
    $error("pmcdr_regs: LIMIT_W must be 16");
  end

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  logic [7:0]    tune;
  logic [7:0]    next_tune;
  logic          wake_d3cold;
  logic          next_wake_d3cold;
  logic [7:0]    next_cfg_rdata;
  logic          next_cfg_rvalid;
  logic          next_status_change_to_host;
  pmcdr_tuning_t next_tuning;
  logic [15:0]   power_cap;
  logic          route_ok;

  // capability word assembled from fixed fields and the one writable bit
  always_comb begin
    power_cap = {wake_d3cold, WAKE_FIXED_STATES, STATE_TWO_ONE_SUPPORT,
                 CAP_RSVD_VALUE, DEVICE_INIT_NEEDED,
                 wake_d3cold, WAKE_NEEDS_CLOCK, PM_VERSION};
  end

  // ---------------------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------------------
  // only writable bits take data; fixed tuning bit 6 is stored forced to one, capability fixed bits hold no state
  always_comb begin
    next_tune = tune;
    next_wake_d3cold = wake_d3cold;
    if (cfg_req.wr) begin
      case (cfg_req.addr)
        OFS_TEST_TUNING_CONTROL: begin
          next_tune = cfg_req.wdata | TUNE_FORCE_ONE;
        end
        OFS_POWER_CAP_HI: begin
          next_wake_d3cold = cfg_req.wdata[BIT_WAKE_D3COLD - 8];
        end
        default: begin
          next_tune = tune;  // read-only, reserved and unmapped bytes drop the write
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tune <= TUNE_RESET;
      wake_d3cold <= POWER_CAP_RESET[BIT_WAKE_D3COLD];
    end else begin
      tune <= next_tune;
      wake_d3cold <= next_wake_d3cold;
    end
  end

  // ---------------------------------------------------------------------------
  // register reads
  // ---------------------------------------------------------------------------
  // read data registered; answer one cycle after the request, unmapped reads 00h
  always_comb begin
    next_cfg_rvalid = cfg_req.rd;
    next_cfg_rdata = cfg_rdata;
    if (cfg_req.rd) begin
      case (cfg_req.addr)
        OFS_VENDOR_LO: begin
          next_cfg_rdata = tune[BIT_ID_MASK_SELECT] ? ALL_ONES_BYTE : VENDOR_ID[7:0];
        end
        OFS_VENDOR_HI: begin
          next_cfg_rdata = tune[BIT_ID_MASK_SELECT] ? ALL_ONES_BYTE : VENDOR_ID[15:8];
        end
        OFS_DEVICE_LO: begin
          next_cfg_rdata = tune[BIT_ID_MASK_SELECT] ? ALL_ONES_BYTE : DEVICE_ID[7:0];
        end
        OFS_DEVICE_HI: begin
          next_cfg_rdata = tune[BIT_ID_MASK_SELECT] ? ALL_ONES_BYTE : DEVICE_ID[15:8];
        end
        OFS_TEST_TUNING_CONTROL: begin
          next_cfg_rdata = tune | TUNE_FORCE_ONE;
        end
        OFS_CAPABILITY_IDENTIFIER: begin
          next_cfg_rdata = CAP_ID_VALUE;
        end
        OFS_NEXT_ITEM_POINTER: begin
          next_cfg_rdata = NEXT_PTR_VALUE;
        end
        OFS_POWER_CAP_LO: begin
          next_cfg_rdata = power_cap[7:0];
        end
        OFS_POWER_CAP_HI: begin
          next_cfg_rdata = power_cap[15:8];
        end
        default: begin
          next_cfg_rdata = NEXT_PTR_VALUE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_rdata <= 8'h00;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rdata <= next_cfg_rdata;
      cfg_rvalid <= next_cfg_rvalid;
    end
  end

  // ---------------------------------------------------------------------------
  // status change routing and tuning outputs
  // ---------------------------------------------------------------------------
  // routing decided from live legacy register contents, no copy kept here
  always_comb begin
    if (tune[BIT_STATUS_CHANGE_ROUTING]) begin
      route_ok = (legacy_card_reg805[7:4] == LEGACY805_ROUTE_VALUE);
    end else begin
      route_ok = legacy_card_reg803[BIT_LEGACY803_ROUTE];
    end
    next_status_change_to_host = status_change_event & route_ok;
    next_tuning.delayed_txn_disable = tune[BIT_DELAYED_TXN_DISABLE];
    next_tuning.retry_latency = tune[BIT_RETRY_LATENCY_EXTEND] ?
                                7'(RETRY_LONG) : 7'(RETRY_SHORT);
    next_tuning.card_discard_limit = tune[BIT_CARD_DISCARD_SEL] ?
                                     16'(1 << DISCARD_EXP_SHORT) : 16'(1 << DISCARD_EXP_LONG);
    next_tuning.host_discard_limit = tune[BIT_HOST_DISCARD_SEL] ?
                                     16'(1 << DISCARD_EXP_SHORT) : 16'(1 << DISCARD_EXP_LONG);
    next_tuning.video_model_enable = ~tune[BIT_VIDEO_MODEL_DISABLE];
  end

  // registered so downstream timers see a clean value two cycles after a write
  always_ff @(posedge clk) begin
    if (srst) begin
      status_change_to_host <= 1'b0;
      tuning.delayed_txn_disable <= TUNE_RESET[BIT_DELAYED_TXN_DISABLE];
      tuning.retry_latency <= 7'(RETRY_SHORT);
      tuning.card_discard_limit <= 16'(1 << DISCARD_EXP_LONG);
      tuning.host_discard_limit <= 16'(1 << DISCARD_EXP_LONG);
      tuning.video_model_enable <= 1'b1;
    end else begin
      status_change_to_host <= next_status_change_to_host;
      tuning <= next_tuning;
    end
  end

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_read(logic [7:0] a);
    cfg_req.rd && !cfg_req.wr && cfg_req.addr == a;
  endsequence

  sequence s_write_tune;
    cfg_req.wr && cfg_req.addr == OFS_TEST_TUNING_CONTROL;
  endsequence

  sequence s_write_wake;
    cfg_req.wr && cfg_req.addr == OFS_POWER_CAP_HI;
  endsequence

  AST_ID_MASK: assert property (
    (s_read(OFS_VENDOR_LO) or s_read(OFS_DEVICE_HI)) |=>
      cfg_rvalid && (cfg_rdata == ALL_ONES_BYTE) == $past(tune[BIT_ID_MASK_SELECT]))
    else $error("id read masking wrong");

  // every tuning readback, whatever was written before it
  AST_RSVD_ONE: assert property (
    s_read(OFS_TEST_TUNING_CONTROL) |=> cfg_rvalid && cfg_rdata[BIT_TUNE_RSVD])
    else $error("tuning bit 6 not one");

  AST_STATUS_ROUTE: assert property (
    status_change_event && tune[BIT_STATUS_CHANGE_ROUTING] |=>
      status_change_to_host == ($past(legacy_card_reg805[7:4]) == LEGACY805_ROUTE_VALUE))
    else $error("status change routing wrong");

  AST_DELAYED: assert property (
    s_write_tune |-> ##2 tuning.delayed_txn_disable == $past(cfg_req.wdata[BIT_DELAYED_TXN_DISABLE], 2))
    else $error("delayed transaction disable not applied");

  AST_RETRY: assert property (
    s_write_tune ##2 1'b1 |-> tuning.retry_latency ==
      ($past(cfg_req.wdata[BIT_RETRY_LATENCY_EXTEND], 2) ? 7'(RETRY_LONG) : 7'(RETRY_SHORT)))
    else $error("retry latency wrong");

  AST_DISC_CARD: assert property (
    ##1 tuning.card_discard_limit ==
      ($past(tune[BIT_CARD_DISCARD_SEL]) ? 16'h0400 : 16'h8000))
    else $error("card discard limit wrong");

  AST_DISC_HOST: assert property (
    ##1 tuning.host_discard_limit ==
      ($past(tune[BIT_HOST_DISCARD_SEL]) ? 16'h0400 : 16'h8000))
    else $error("host discard limit wrong");

  AST_VIDEO: assert property (
    s_write_tune |-> ##2 tuning.video_model_enable != $past(cfg_req.wdata[BIT_VIDEO_MODEL_DISABLE], 2))
    else $error("video model enable wrong");

  AST_CAP_ID: assert property (
    s_read(OFS_CAPABILITY_IDENTIFIER) |=> cfg_rvalid && cfg_rdata == 8'h01)
    else $error("capability_identifier wrong");

  AST_NEXT_PTR: assert property (
    s_read(OFS_NEXT_ITEM_POINTER) |=> cfg_rvalid && cfg_rdata == 8'h00)
    else $error("next pointer wrong");

  AST_CAP_HI: assert property (
    s_read(OFS_POWER_CAP_HI) |=> cfg_rdata[6:0] == 7'h7e && cfg_rdata[7] == $past(wake_d3cold))
    else $error("capability high byte wrong");

  AST_AUX_MIRROR: assert property (
    s_read(OFS_POWER_CAP_LO) |=>
      cfg_rvalid && cfg_rdata == {2'h0, 1'b1, $past(wake_d3cold), 1'b0, 3'h2})
    else $error("aux power mirror wrong");

  // any write outside the two writable bytes must leave stored state alone
  AST_RO_WRITE: assert property (
    cfg_req.wr && cfg_req.addr != OFS_TEST_TUNING_CONTROL && cfg_req.addr != OFS_POWER_CAP_HI
      |=> $stable(tune) && $stable(wake_d3cold))
    else $error("read-only register changed");

  // vendor high byte checked too, so three of the four id bytes are covered; device low byte is not
  AST_ID_HI_BYTE: assert property (
    s_read(OFS_VENDOR_HI) |=> cfg_rvalid &&
      cfg_rdata == ($past(tune[BIT_ID_MASK_SELECT]) ? ALL_ONES_BYTE : VENDOR_ID[15:8]))
    else $error("vendor id high byte wrong");

  // fixed low-byte fields, apart from the mirror check so each rule fails alone
  AST_CAP_LO_FIXED: assert property (
    s_read(OFS_POWER_CAP_LO) |=> cfg_rvalid && cfg_rdata[7:5] == 3'h1 && cfg_rdata[3:0] == 4'h2)
    else $error("capability low byte fixed fields wrong");

  AST_STATE_SUPPORT: assert property (
    s_read(OFS_POWER_CAP_HI) |=> cfg_rvalid && cfg_rdata[2:1] == 2'h3 && !cfg_rdata[0])
    else $error("power state support bits wrong");

  // wake bit is the only stored capability bit; a lost write would hide cold wake
  AST_WAKE_WRITE: assert property (
    s_write_wake |=> wake_d3cold == $past(cfg_req.wdata[BIT_WAKE_D3COLD - 8]))
    else $error("cold wake bit write lost");

  AST_ROUTE_LEGACY: assert property (
    status_change_event && !tune[BIT_STATUS_CHANGE_ROUTING] |=>
      status_change_to_host == $past(legacy_card_reg803[BIT_LEGACY803_ROUTE]))
    else $error("legacy status routing wrong");

  // no event, no forward: the output is high only in the cycle after an event
  AST_NO_EVENT: assert property (
    !status_change_event |=> !status_change_to_host)
    else $error("status change forwarded without event");

endmodule  // pmcdr_regs

// ==== dv/pmcdr_host_model.sv ====
// configuration host model issuing byte reads and writes to the tuning and capability bank
`timescale 1ns/100ps
module pmcdr_host_model
  import pmcdr_pkg::*;
(
  input  wire logic       clk,
  output pmcdr_cfg_req_t  cfg_req,
  input  wire logic [7:0] cfg_rdata,
  input  wire logic       cfg_rvalid
);
  // idle bus at time zero
  initial cfg_req = '0;
  // ---------------------------------------------------------------------------
  // bus cycles
  // ---------------------------------------------------------------------------
  // one-cycle strobe; address and data scrambled once released so stale values never pass
  task automatic cfg_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    cfg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    cfg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  // answer taken at the falling edge after the strobe edge, where it has settled
  task automatic cfg_read(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge clk);
    cfg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~cfg_req.wdata};
    @(negedge clk);
    cfg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: cfg_req.wdata};
    d = cfg_rdata;
    v = cfg_rvalid;
  endtask
  // advised tuning value for normal operation
  task automatic tune_clear();
    cfg_write(OFS_TEST_TUNING_CONTROL, 8'h00);
  endtask
  // firmware drops cold wake when no auxiliary power is supplied
  task automatic fw_clear_wake();
    cfg_write(OFS_POWER_CAP_HI, 8'h00);
  endtask
endmodule  // pmcdr_host_model

// ==== dv/testbench.sv ====
// self-checking bench for the tuning register and power capability header
`timescale 1ns/100ps
module testbench
  import pmcdr_pkg::*;
;
  localparam logic [15:0] VID = 16'h2b7c;  // arbitrary value
  localparam logic [15:0] DID = 16'h91e4;  // arbitrary value
  logic           clk = 1'b0;
  logic           srst = 1'b1;
  pmcdr_cfg_req_t cfg_req;
  logic [7:0]     cfg_rdata;
  logic           cfg_rvalid;
  logic [7:0]     reg803 = 8'h00;
  logic [7:0]     reg805 = 8'h00;
  logic           evt = 1'b0;
  logic           sc_host;
  pmcdr_tuning_t  tuning;
  int             fails = 0;
  int             samples_checked = 0;
  int             tune_m;
  int             wake_m;
  logic [7:0]     addrs [10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h93, 8'ha0, 8'ha1, 8'ha2, 8'ha3, 8'h50};
  // ---------------------------------------------------------------------------
  // clock, design and host
  // ---------------------------------------------------------------------------
  initial forever #2 clk = ~clk;
  pmcdr_regs #(.VENDOR_ID(VID), .DEVICE_ID(DID), .LIMIT_W(16)) i_dut (
    .clk(clk), .srst(srst), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .legacy_card_reg803(reg803), .legacy_card_reg805(reg805), .status_change_event(evt),
    .status_change_to_host(sc_host), .tuning(tuning));
  pmcdr_host_model i_host (.clk(clk), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid));
  // ---------------------------------------------------------------------------
  // reference model and checks
  // ---------------------------------------------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // bit 6 is never stored, it only shows on reads
  task automatic model_wr(input logic [7:0] a, input logic [7:0] d);
    if (a == OFS_TEST_TUNING_CONTROL) tune_m = d & 8'hbf;
    if (a == OFS_POWER_CAP_HI) wake_m = d[7];
  endtask
  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    case (a)
      8'h00: exp_rd = tune_m[7] ? 8'hff : VID[7:0];
      8'h01: exp_rd = tune_m[7] ? 8'hff : VID[15:8];
      8'h02: exp_rd = tune_m[7] ? 8'hff : DID[7:0];
      8'h03: exp_rd = tune_m[7] ? 8'hff : DID[15:8];
      8'h93: exp_rd = 8'(tune_m | 8'h40);
      8'ha0: exp_rd = 8'h01;
      8'ha1: exp_rd = 8'h00;
      8'ha2: exp_rd = {2'b00, 1'b1, wake_m[0], 1'b0, 3'b010};
      8'ha3: exp_rd = {wake_m[0], 7'h7e};
      default: exp_rd = 8'h00;
    endcase
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host.cfg_write(a, d);
    model_wr(a, d);
  endtask
  // every mapped byte, one unmapped byte, then the tuning outputs
  task automatic check_all();
    logic [7:0]    d;
    logic          v;
    pmcdr_tuning_t t;
    foreach (addrs[i]) begin
      i_host.cfg_read(addrs[i], d, v);
      check(v, 1'b1);
      check(d, exp_rd(addrs[i]));
    end
    t.delayed_txn_disable = tune_m[4];
    t.retry_latency = tune_m[3] ? 7'd64 : 7'd16;
    t.card_discard_limit = tune_m[2] ? 16'd1024 : 16'd32768;
    t.host_discard_limit = tune_m[1] ? 16'd1024 : 16'd32768;
    t.video_model_enable = !tune_m[0];
    check({23'h0, tuning}, {23'h0, t});
  endtask
  task automatic do_reset();
    @(negedge clk);
    srst <= 1'b1;
    repeat (6) @(negedge clk);
    srst <= 1'b0;
    tune_m = 8'h20;
    wake_m = 1;
    check(cfg_rvalid, 1'b0);
    check(sc_host, 1'b0);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ---------------------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------------------
  initial begin
    #(4 * 20000);
    fails++;
    end_of_test();
  end
  initial begin
    logic [7:0] r803;
    logic [7:0] r805;
    void'($urandom(32'h0f516e61));
    do_reset();
    check_all();
    $display("reset values done");
    // read-only bytes and low capability byte ignore writes
    foreach (addrs[i]) if (addrs[i] != 8'h93 && addrs[i] != 8'ha3) wr(addrs[i], 8'hff);
    check_all();
    $display("read-only writes done");
    // corner and random tuning values, mask on and off
    wr(8'h93, 8'hff);
    check_all();
    i_host.tune_clear();
    model_wr(8'h93, 8'h00);
    check_all();
    repeat (6) begin
      wr(8'h93, 8'($urandom));
      check_all();
    end
    $display("tuning values done");
    // cold wake bit cleared by firmware and set again, aux bit follows
    i_host.fw_clear_wake();
    model_wr(8'ha3, 8'h00);
    check_all();
    wr(8'ha3, 8'hff);
    check_all();
    $display("wake bit done");
    // status change routing under both selections with random legacy contents
    for (int s = 0; s < 2; s++) begin
      wr(8'h93, 8'(s << 5));
      repeat (12) begin
        r803 = 8'($urandom);
        r805 = ($urandom % 2) ? (8'($urandom) & 8'h0f) : 8'($urandom);
        @(negedge clk);
        reg803 <= r803;
        reg805 <= r805;
        evt <= 1'b1;
        @(negedge clk);
        evt <= 1'b0;
        check(sc_host, s ? (r805[7:4] == 4'h0) : r803[4]);
        @(negedge clk);
        check(sc_host, 1'b0);
      end
    end
    $display("status routing done");
    // reset in mid-run restores defaults
    wr(8'h93, 8'h9f);
    wr(8'ha3, 8'h00);
    do_reset();
    check_all();
    $display("second reset done");
    end_of_test();
  end
endmodule  // testbench
